// ---- hdl/enc_cnt_regs.vh ----
`ifndef ENC_CNT_REGS_VH
`define ENC_CNT_REGS_VH
// Clock rate and filter timing
`define CLK_FREQ_HZ 100000000
`define CLK_PERIOD_NS 10
`define FILT_SEL_W 4
`define FILT_CNT_W 19
// Minimum pulse/break times in ns
`define FILT_T0_NS 4000000
`define FILT_T1_NS 2000000
`define FILT_T2_NS 800000
`define FILT_T3_NS 400000
`define FILT_T4_NS 200000
`define FILT_T5_NS 80000
`define FILT_T6_NS 40000
`define FILT_T7_NS 20000
`define FILT_T8_NS 8000
`define FILT_T9_NS 4000
`define FILT_T10_NS 2000
`define FILT_T11_NS 800
`define FILT_T12_NS 400
// Configuration encodings
`define SIG_INC_ABN 3'h1
`define EVAL_SINGLE 2'h0
`define EVAL_DOUBLE 2'h1
`define EVAL_QUAD 2'h2
`define NREACT_NONE 2'h0
`define NREACT_SYNC 2'h1
`define NREACT_CAPT 2'h2
`define FREQ_ONCE 1'h0
`define FREQ_PERIODIC 1'h1
// Reset values
`define CNT_HIGH_DEF 32'h7fffffff
`define CNT_LOW_DEF 32'h80000000
`define CNT_START_DEF 32'h00000000
`define CAPT_RESET_DEF 32'h00000000
`endif

// ---- hdl/input_filter.v ----
`timescale 1ns/1ps
`include "enc_cnt_regs.vh"
module input_filter (
  input wire core_clk_in,
  input wire nrst_in,
  input wire raw_in,
  input wire [`FILT_SEL_W-1:0] filt_sel_in,
  output reg level_out
);
  reg sync1_r;
  reg sync2_r;
  reg [`FILT_CNT_W-1:0] cnt_r;
  reg [31:0] limit_full;
  wire [`FILT_CNT_W-1:0] limit;

  // Clock cycles in the minimum time; the longest setting fits the counter width
  assign limit = limit_full[`FILT_CNT_W-1:0];
  always @* begin
    case (filt_sel_in)
      4'h0: limit_full = `FILT_T0_NS / `CLK_PERIOD_NS;
      4'h1: limit_full = `FILT_T1_NS / `CLK_PERIOD_NS;
      4'h2: limit_full = `FILT_T2_NS / `CLK_PERIOD_NS;
      4'h3: limit_full = `FILT_T3_NS / `CLK_PERIOD_NS;
      4'h4: limit_full = `FILT_T4_NS / `CLK_PERIOD_NS;
      4'h5: limit_full = `FILT_T5_NS / `CLK_PERIOD_NS;
      4'h6: limit_full = `FILT_T6_NS / `CLK_PERIOD_NS;
      4'h7: limit_full = `FILT_T7_NS / `CLK_PERIOD_NS;
      4'h8: limit_full = `FILT_T8_NS / `CLK_PERIOD_NS;
      4'h9: limit_full = `FILT_T9_NS / `CLK_PERIOD_NS;
      4'ha: limit_full = `FILT_T10_NS / `CLK_PERIOD_NS;
      4'hb: limit_full = `FILT_T11_NS / `CLK_PERIOD_NS;
      default: limit_full = `FILT_T12_NS / `CLK_PERIOD_NS;
    endcase
  end

  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      cnt_r <= {`FILT_CNT_W{1'b0}};
      level_out <= 1'b0;
    end else begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
      if (sync2_r == level_out) begin
        cnt_r <= {`FILT_CNT_W{1'b0}};
      end else if (cnt_r >= limit - 19'h00001) begin
        cnt_r <= {`FILT_CNT_W{1'b0}};
        level_out <= sync2_r;
      end else begin
        cnt_r <= cnt_r + 19'h00001;
      end
    end
  end
endmodule

// ---- hdl/edge_detect.v ----
`timescale 1ns/1ps
module edge_detect (
  input wire core_clk_in,
  input wire nrst_in,
  input wire sig_in,
  output wire rise_out,
  output wire fall_out
);
  reg prev_r;
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= sig_in;
    end
  end
  assign rise_out = sig_in & ~prev_r;
  assign fall_out = ~sig_in & prev_r;
endmodule

// ---- hdl/encoder_count_sync_capture.v ----
`timescale 1ns/1ps
`include "enc_cnt_regs.vh"
module encoder_count_sync_capture (
  input wire core_clk_in,
  input wire nrst_in,
  input wire enc_a_in,
  input wire enc_b_in,
  input wire enc_n_in,
  input wire di_sync_en_in,
  input wire di_sync_in,
  input wire di_capt_in,
  input wire [`FILT_SEL_W-1:0] filt_sel_in,
  input wire [2:0] sig_type_in,
  input wire [1:0] eval_mode_in,
  input wire invert_dir_in,
  input wire [1:0] n_react_in,
  input wire sync_freq_in,
  input wire capt_freq_in,
  input wire ref_mode_in,
  input wire sync_en_used_in,
  input wire sync_di_used_in,
  input wire capt_di_used_in,
  input wire wrap_to_start_in,
  input wire [31:0] high_limit_in,
  input wire [31:0] low_limit_in,
  input wire [31:0] start_value_in,
  input wire restart_in,
  output reg [31:0] count_out,
  output reg [31:0] capture_result_output,
  output reg sync_event_out,
  output reg capt_event_out
);
  wire a_f;
  wire b_f;
  wire n_f;
  wire a_rise;
  wire a_fall;
  wire b_rise;
  wire b_fall;
  wire n_rise;
  wire n_fall;
  wire dsy_rise;
  wire dcp_rise;
  reg dsy1_r;
  reg dsy2_r;
  reg dcp1_r;
  reg dcp2_r;
  reg den1_r;
  reg den2_r;
  reg sync_done_r;
  reg capt_done_r;
  reg step_up;
  reg step_dn;
  reg sync_ev;
  reg capt_ev;
  reg [31:0] count_nxt;
  reg [32:0] wide;
  reg sync_done_nxt;
  reg capt_done_nxt;
  reg [31:0] capture_nxt;
  wire [32:0] high_ext;
  wire [32:0] low_ext;
  wire [31:0] wrap_up_val;
  wire [31:0] wrap_dn_val;

  // Limits sign-extended for the overrun test, and the reload values on overrun
  assign high_ext = {high_limit_in[31], high_limit_in};
  assign low_ext = {low_limit_in[31], low_limit_in};
  assign wrap_up_val = wrap_to_start_in ? start_value_in : low_limit_in;
  assign wrap_dn_val = wrap_to_start_in ? start_value_in : high_limit_in;

  // selection held in filt_sel_in, one filter per encoder input A, B and N; the digital inputs are not filtered
  input_filter u_filt_a (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .raw_in(enc_a_in),
    .filt_sel_in(filt_sel_in),
    .level_out(a_f)
  );
  input_filter u_filt_b (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .raw_in(enc_b_in),
    .filt_sel_in(filt_sel_in),
    .level_out(b_f)
  );
  input_filter u_filt_n (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .raw_in(enc_n_in),
    .filt_sel_in(filt_sel_in),
    .level_out(n_f)
  );

  edge_detect u_ed_a (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .sig_in(a_f),
    .rise_out(a_rise),
    .fall_out(a_fall)
  );
  edge_detect u_ed_b (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .sig_in(b_f),
    .rise_out(b_rise),
    .fall_out(b_fall)
  );
  edge_detect u_ed_n (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .sig_in(n_f),
    .rise_out(n_rise),
    .fall_out(n_fall)
  );
  edge_detect u_ed_dsy (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .sig_in(dsy2_r),
    .rise_out(dsy_rise),
    .fall_out()
  );
  edge_detect u_ed_dcp (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .sig_in(dcp2_r),
    .rise_out(dcp_rise),
    .fall_out()
  );

  // Digital inputs synchronised
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dsy1_r <= 1'b0;
      dsy2_r <= 1'b0;
      dcp1_r <= 1'b0;
      dcp2_r <= 1'b0;
      den1_r <= 1'b0;
      den2_r <= 1'b0;
    end else begin
      dsy1_r <= di_sync_in;
      dsy2_r <= dsy1_r;
      dcp1_r <= di_capt_in;
      dcp2_r <= dcp1_r;
      den1_r <= di_sync_en_in;
      den2_r <= den1_r;
    end
  end

  // Quadrature stepping
  always @* begin
    step_up = 1'b0;
    step_dn = 1'b0;
    case (eval_mode_in)
      `EVAL_SINGLE: begin
        step_up = a_rise & ~b_f;
        step_dn = a_fall & ~b_f;
      end
      `EVAL_DOUBLE: begin
        step_up = (a_rise & ~b_f) | (a_fall & b_f);
        step_dn = (a_rise & b_f) | (a_fall & ~b_f);
      end
      `EVAL_QUAD: begin
        step_up = (a_rise & ~b_f) | (a_fall & b_f) | (b_rise & a_f) | (b_fall & ~a_f);
        step_dn = (a_rise & b_f) | (a_fall & ~b_f) | (b_rise & ~a_f) | (b_fall & a_f);
      end
      default: begin
        step_up = 1'b0;
        step_dn = 1'b0;
      end
    endcase
    if (invert_dir_in) begin
      {step_up, step_dn} = {step_dn, step_up};
    end
  end

  // Sync and capture triggers
  always @* begin
    sync_ev = 1'b0;
    capt_ev = 1'b0;
    if (sig_type_in == `SIG_INC_ABN && n_react_in == `NREACT_SYNC && n_rise) begin
      sync_ev = ~sync_en_used_in | den2_r;
    end
    if (sync_di_used_in && dsy_rise) begin
      sync_ev = 1'b1;
    end
    if (sync_freq_in == `FREQ_ONCE && sync_done_r) begin
      sync_ev = 1'b0;
    end
    if (sig_type_in == `SIG_INC_ABN && n_react_in == `NREACT_CAPT && n_rise
        && ref_mode_in) begin
      capt_ev = 1'b1;
    end
    if (capt_di_used_in && dcp_rise) begin
      capt_ev = 1'b1;
    end
    if (capt_freq_in == `FREQ_ONCE && capt_done_r) begin
      capt_ev = 1'b0;
    end
  end

  // Count next value, signed 32-bit arithmetic
  always @* begin
    count_nxt = count_out;
    wide = {count_out[31], count_out};
    if (step_up && !step_dn) begin
      wide = {count_out[31], count_out} + 33'h000000001;
      if ($signed(wide) > $signed(high_ext)) begin
        count_nxt = wrap_up_val;
      end else begin
        count_nxt = wide[31:0];
      end
    end else if (step_dn && !step_up) begin
      wide = {count_out[31], count_out} - 33'h000000001;
      if ($signed(wide) < $signed(low_ext)) begin
        count_nxt = wrap_dn_val;
      end else begin
        count_nxt = wide[31:0];
      end
    end
    if (sync_ev) begin
      count_nxt = start_value_in;
    end
    if (restart_in) begin
      count_nxt = start_value_in;
    end
  end

  // An event in the same cycle as restart_in still sets its once-flag
  always @* begin
    sync_done_nxt = sync_done_r;
    capt_done_nxt = capt_done_r;
    if (restart_in) begin
      sync_done_nxt = 1'b0;
      capt_done_nxt = 1'b0;
    end
    if (sync_ev) begin
      sync_done_nxt = 1'b1;
    end
    if (capt_ev) begin
      capt_done_nxt = 1'b1;
    end
  end

  // Capture register holds its value between events
  always @* begin
    capture_nxt = capture_result_output;
    if (capt_ev) begin
      capture_nxt = count_out;
    end
  end

  // without a sync event, N leaves count_nxt untouched
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count_out <= `CNT_START_DEF;
      sync_event_out <= 1'b0;
      capt_event_out <= 1'b0;
    end else begin
      count_out <= count_nxt;
      sync_event_out <= sync_ev;
      capt_event_out <= capt_ev;
    end
  end

  // Count value taken at the event, before that cycle's update
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      capture_result_output <= `CAPT_RESET_DEF;
    end else begin
      capture_result_output <= capture_nxt;
    end
  end

  // Once-flags, cleared by restart_in and reset
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync_done_r <= 1'b0;
      capt_done_r <= 1'b0;
    end else begin
      sync_done_r <= sync_done_nxt;
      capt_done_r <= capt_done_nxt;
    end
  end
endmodule

// ---- tb/encoder_count_sync_capture_monitor.sv ----
`timescale 1ns/1ps
`include "enc_cnt_regs.vh"
module encoder_count_sync_capture_monitor (
  input wire core_clk_in,
  input wire nrst_in,
  input wire [2:0] sig_type_in,
  input wire [1:0] n_react_in,
  input wire sync_freq_in,
  input wire ref_mode_in,
  input wire sync_di_used_in,
  input wire capt_di_used_in,
  input wire [31:0] high_limit_in,
  input wire [31:0] low_limit_in,
  input wire [31:0] start_value_in,
  input wire restart_in,
  input wire [31:0] count_out,
  input wire [31:0] capture_result_output,
  input wire sync_event_out,
  input wire capt_event_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  // Syncs since the last restart
  reg [3:0] syncs_r;
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) syncs_r <= 4'h0;
    else if (restart_in) syncs_r <= 4'h0;
    else if (sync_event_out && syncs_r != 4'hf) syncs_r <= syncs_r + 4'h1;
  end
  sync_load_a: assert property (sync_event_out |-> count_out == $past(start_value_in))
    else $error("sync did not load start value");
  capt_copy_a: assert property (capt_event_out |-> capture_result_output == $past(count_out))
    else $error("capture value wrong");
  capt_hold_a: assert property (!capt_event_out |-> $stable(capture_result_output))
    else $error("capture changed without event");
  no_react_a: assert property ($past(n_react_in) == `NREACT_NONE && !$past(sync_di_used_in)
    |-> !sync_event_out) else $error("sync with no reaction set");
  sig_type_a: assert property ($past(sig_type_in) != `SIG_INC_ABN && !$past(capt_di_used_in)
    |-> !capt_event_out) else $error("capture with wrong signal type");
  ref_mode_a: assert property (!$past(ref_mode_in) && !$past(capt_di_used_in)
    |-> !capt_event_out) else $error("capture outside reference mode");
  limit_range_a: assert property ($signed(count_out) <= $signed(high_limit_in) &&
    $signed(count_out) >= $signed(low_limit_in)) else $error("count outside limits");
  sync_once_a: assert property (sync_freq_in == `FREQ_ONCE && sync_event_out
    |-> syncs_r == 4'h0) else $error("second sync in once mode");
endmodule
bind encoder_count_sync_capture encoder_count_sync_capture_monitor i_monitor (
  .core_clk_in, .nrst_in, .sig_type_in, .n_react_in, .sync_freq_in, .ref_mode_in,
  .sync_di_used_in, .capt_di_used_in, .high_limit_in, .low_limit_in, .start_value_in,
  .restart_in, .count_out, .capture_result_output, .sync_event_out, .capt_event_out);

// ---- tb/encoder_model.sv ----
`timescale 1ns/1ps
module encoder_model #(parameter integer HOLD = 60) (
  input wire core_clk_in,
  output reg enc_a_out,
  output reg enc_b_out,
  output reg enc_n_out
);
  reg [1:0] ph_r;
  initial begin
    ph_r = 2'h0;
    enc_a_out = 1'b0;
    enc_b_out = 1'b0;
    enc_n_out = 1'b0;
  end
  // One forward quadrature edge, A leading B
  task step;
    begin
      @(posedge core_clk_in);
      ph_r = ph_r + 2'h1;
      enc_a_out <= (ph_r == 2'h1) || (ph_r == 2'h2);
      enc_b_out <= ph_r[1];
      repeat (HOLD) @(posedge core_clk_in);
    end
  endtask
  // Zero mark pulse
  task zero;
    begin
      @(posedge core_clk_in);
      enc_n_out <= 1'b1;
      repeat (HOLD) @(posedge core_clk_in);
      enc_n_out <= 1'b0;
      repeat (HOLD) @(posedge core_clk_in);
    end
  endtask
  // Pulse on A shorter than the filter time
  task glitch;
    begin
      @(posedge core_clk_in);
      enc_a_out <= ~enc_a_out;
      repeat (20) @(posedge core_clk_in);
      enc_a_out <= ~enc_a_out;
      repeat (HOLD) @(posedge core_clk_in);
    end
  endtask
endmodule

// ---- tb/tb_encoder_count_sync_capture.sv ----
`timescale 1ns/1ps
`include "enc_cnt_regs.vh"
module tb_encoder_count_sync_capture;
  localparam [31:0] hi_lim = 32'h0000000a;
  localparam [31:0] lo_lim = 32'hfffffffd;
  localparam [31:0] st_val = 32'h00000002;
  reg core_clk_in, nrst_in, di_sync_en_in, di_sync_in, di_capt_in, invert_dir_in, restart_in;
  reg sync_freq_in, capt_freq_in, ref_mode_in, sync_en_used_in, sync_di_used_in;
  reg capt_di_used_in, wrap_to_start_in;
  reg [1:0] eval_mode_in, n_react_in;
  reg [2:0] sig_type_in;
  reg [3:0] filt_sel_in;
  reg [31:0] e;
  wire enc_a_in, enc_b_in, enc_n_in, sync_event_out, capt_event_out;
  wire [31:0] count_out, capture_result_output;
  integer miscompares = 0, total_checks = 0, m, r;
  logic [31:0] sq[$], kq[$];
  encoder_model i_encoder_model (.core_clk_in(core_clk_in), .enc_a_out(enc_a_in),
    .enc_b_out(enc_b_in), .enc_n_out(enc_n_in));
  encoder_count_sync_capture i_encoder_count_sync_capture (.core_clk_in(core_clk_in),
    .nrst_in(nrst_in), .enc_a_in(enc_a_in), .enc_b_in(enc_b_in), .enc_n_in(enc_n_in),
    .di_sync_en_in(di_sync_en_in), .di_sync_in(di_sync_in), .di_capt_in(di_capt_in),
    .filt_sel_in(filt_sel_in), .sig_type_in(sig_type_in), .eval_mode_in(eval_mode_in),
    .invert_dir_in(invert_dir_in), .n_react_in(n_react_in), .sync_freq_in(sync_freq_in),
    .capt_freq_in(capt_freq_in), .ref_mode_in(ref_mode_in),
    .sync_en_used_in(sync_en_used_in), .sync_di_used_in(sync_di_used_in),
    .capt_di_used_in(capt_di_used_in), .wrap_to_start_in(wrap_to_start_in),
    .high_limit_in(hi_lim), .low_limit_in(lo_lim), .start_value_in(st_val),
    .restart_in(restart_in), .count_out(count_out),
    .capture_result_output(capture_result_output), .sync_event_out(sync_event_out),
    .capt_event_out(capt_event_out));
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task cmp_count(input [31:0] exp);
    cmp(count_out, exp);
  endtask
  task cmp_capt(input [31:0] exp);
    cmp(capture_result_output, exp);
  endtask
  task test_done;
    begin
      if (miscompares == 0 && total_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task wt(input integer n);
    repeat (n) @(posedge core_clk_in);
  endtask
  task rst;
    begin
      @(posedge core_clk_in);
      restart_in <= 1'b1;
      @(posedge core_clk_in);
      restart_in <= 1'b0;
      wt(6);
      e = st_val;
    end
  endtask
  function [31:0] up(input [31:0] v);
    up = (v == hi_lim) ? (wrap_to_start_in ? st_val : lo_lim) : v + 32'h1;
  endfunction
  task fwd(input integer n);
    repeat (n) begin
      i_encoder_model.step;
      if (eval_mode_in == `EVAL_QUAD) e = up(e);
    end
  endtask
  task dcap;
    begin
      @(posedge core_clk_in);
      di_capt_in <= 1'b1;
      wt(10);
      di_capt_in <= 1'b0;
      wt(10);
    end
  endtask
  task dsync;
    begin
      @(posedge core_clk_in);
      di_sync_in <= 1'b1;
      wt(10);
      di_sync_in <= 1'b0;
      wt(10);
    end
  endtask
  // Scoreboard for event results
  always @(posedge core_clk_in) begin
    if (sync_event_out === 1'b1) begin
      if (sq.size() == 0) cmp(32'h1, 32'h0);
      else cmp_count(sq.pop_front());
    end
    if (capt_event_out === 1'b1) begin
      if (kq.size() == 0) cmp(32'h1, 32'h0);
      else cmp_capt(kq.pop_front());
    end
  end
  initial begin
    wt(60000);
    miscompares = miscompares + 1;
    test_done;
  end
  initial begin
    r = $urandom(32'h0000a15a);
    {nrst_in, di_sync_en_in, di_sync_in, di_capt_in, invert_dir_in, restart_in} = 6'h0;
    {sync_freq_in, capt_freq_in, ref_mode_in, sync_en_used_in} = 4'he;
    {sync_di_used_in, capt_di_used_in, wrap_to_start_in, n_react_in} = 5'h0;
    {sig_type_in, eval_mode_in, filt_sel_in} = {`SIG_INC_ABN, `EVAL_SINGLE, 4'hc};
    wt(2);
    nrst_in <= 1'b1;
    rst;
    cmp_count(st_val);
    for (m = 0; m < 3; m = m + 1) begin
      eval_mode_in <= m[1:0];
      rst;
      fwd(4);
      cmp_count(st_val + (32'h1 << m));
    end
    i_encoder_model.glitch;
    cmp_count(e);
    i_encoder_model.zero;
    cmp_count(e);
    n_react_in <= `NREACT_SYNC;
    repeat (2) begin
      fwd(1);
      sq.push_back(st_val);
      i_encoder_model.zero;
      e = st_val;
      cmp_count(e);
    end
    sync_en_used_in <= 1'b1;
    fwd(1);
    i_encoder_model.zero;
    cmp_count(e);
    di_sync_en_in <= 1'b1;
    sq.push_back(st_val);
    i_encoder_model.zero;
    e = st_val;
    cmp_count(e);
    sync_en_used_in <= 1'b0;
    sync_freq_in <= `FREQ_ONCE;
    rst;
    fwd(1);
    sq.push_back(st_val);
    i_encoder_model.zero;
    fwd(1);
    i_encoder_model.zero;
    e = st_val + 32'h1;
    cmp_count(e);
    n_react_in <= `NREACT_CAPT;
    ref_mode_in <= 1'b1;
    capt_di_used_in <= 1'b1;
    kq.push_back(e);
    i_encoder_model.zero;
    fwd(1);
    kq.push_back(e);
    dcap;
    capt_freq_in <= `FREQ_ONCE;
    rst;
    fwd(1);
    kq.push_back(e);
    dcap;
    fwd(1);
    i_encoder_model.zero;
    cmp_capt(st_val + 32'h1);
    capt_freq_in <= `FREQ_PERIODIC;
    ref_mode_in <= 1'b0;
    capt_di_used_in <= 1'b0;
    i_encoder_model.zero;
    ref_mode_in <= 1'b1;
    sig_type_in <= 3'h0;
    i_encoder_model.zero;
    sig_type_in <= `SIG_INC_ABN;
    n_react_in <= `NREACT_NONE;
    repeat (6) begin
      wrap_to_start_in <= 1'($urandom);
      fwd($urandom_range(12, 1));
      cmp_count(e);
    end
    sync_freq_in <= `FREQ_PERIODIC;
    sync_di_used_in <= 1'b1;
    sq.push_back(st_val);
    dsync;
    e = st_val;
    cmp_count(e);
    invert_dir_in <= 1'b1;
    i_encoder_model.step;
    e = e - 32'h1;
    cmp_count(e);
    invert_dir_in <= 1'b0;
    cmp(32'(sq.size() + kq.size()), 32'h0);
    test_done;
  end
endmodule
